/* htsp_axil_slave.sv */
// Purpose: AXI4-Lite slave for byte-wide registers
// Assumes: one write and one read outstanding at most
// Notes: write pulse, for a write with wstrb[0] set, in the first cycle that both address and data are held
`timescale 1ns/1ps
`default_nettype none
`include "htsp_consts.svh"
module htsp_axil_slave
   import htsp_pkg::*;
(
   // clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // write channels
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // read channels
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // register side
   output logic             wr_pulse,
   output logic [7:0]       wr_idx,
   output logic [7:0]       wr_data,
   output logic [7:0]       rd_idx,
   input  wire logic [7:0]  rd_data
);

   logic       awready_reg;
   logic       wready_reg;
   logic       bvalid_reg;
   logic [1:0] bresp_reg;
   logic [7:0] aw_idx_reg;
   logic [7:0] w_data_reg;
   logic       w_lane_reg;
   logic       arready_reg;
   logic       rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic       wr_fire;

   assign wr_fire  = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_pulse = wr_fire && w_lane_reg;
   assign wr_idx   = aw_idx_reg;
   assign wr_data  = w_data_reg;
   assign rd_idx   = araddr[9:2];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `HTSP_RESP_OKAY;
         aw_idx_reg  <= 8'h00;
         w_data_reg  <= 8'h00;
         w_lane_reg  <= 1'b0;
      end
      else if (ce)
      begin
         if (awvalid && awready_reg)
         begin
            awready_reg <= 1'b0;
            aw_idx_reg  <= awaddr[9:2];
         end
         if (wvalid && wready_reg)
         begin
            wready_reg <= 1'b0;
            w_data_reg <= wdata[7:0];
            w_lane_reg <= wstrb[0];
         end
         if (wr_fire)
         begin
            bvalid_reg  <= 1'b1;
            bresp_reg   <= htsp_mapped(aw_idx_reg) ? `HTSP_RESP_OKAY : `HTSP_RESP_SLVERR;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
         else if (bvalid_reg && bready)
            bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= `HTSP_RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end
      else if (ce)
      begin
         if (arvalid && arready_reg)
         begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= {24'h00_0000, rd_data};
            rresp_reg   <= htsp_mapped(rd_idx) ? `HTSP_RESP_OKAY : `HTSP_RESP_SLVERR;
         end
         else if (rvalid_reg && rready)
         begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   assign awready = awready_reg;
   assign wready  = wready_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = arready_reg;
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;

endmodule
`default_nettype wire

/* htsp_consts.svh */
// Purpose: offsets, field positions, reset values for host transfer stop pointer
// Assumes: register index times four is the AXI byte address
// Notes: definitions only
`ifndef HTSP_CONSTS_SVH
`define HTSP_CONSTS_SVH

// register indices
`define HTSP_IDX_DMA   8'h53
`define HTSP_IDX_SIZE  8'h54
`define HTSP_IDX_BMRST 8'h59
`define HTSP_IDX_RPL   8'h5a
`define HTSP_IDX_RPH   8'h5b
`define HTSP_IDX_WPL   8'h5c
`define HTSP_IDX_WPH   8'h5d
`define HTSP_IDX_SPL   8'h5e
`define HTSP_IDX_SPH   8'h5f
`define HTSP_IDX_ISTAT 8'h60
`define HTSP_IDX_IMASK 8'h61

// field positions
`define HTSP_BIT_WEN   2
`define HTSP_BIT_REN   3
`define HTSP_BIT_DONE  5
`define HTSP_BIT_BMRST 0
`define HTSP_IRQ_DONE  0
`define HTSP_IRQ_AUTO  1

// reset and load values
`define HTSP_STOP_INIT 16'h01ff
`define HTSP_SPL_AUTO  8'hff
`define HTSP_SPH_INIT  8'h01
`define HTSP_SIZE_RST  8'hff
`define HTSP_PTR_CLR   16'h0000

// bus answers
`define HTSP_RESP_OKAY   2'b00
`define HTSP_RESP_SLVERR 2'b10

`endif

/* htsp_host_model.sv */
// Purpose: host side byte mover for the host transfer stop pointer block
// Assumes: one byte per strobe, strobe only while the device accepts
// Notes: stall pauses the host at random, go enables it
`timescale 1ns/1ps
`default_nettype none
module htsp_host_model
(
   // clock, reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // bench control
   input  wire logic go,
   input  wire logic stall,
   // device side
   input  wire logic xfer_active,
   output logic      byte_strobe
);
   // paced: never two strobes back to back
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         byte_strobe <= 1'b0;
      else
         byte_strobe <= go & xfer_active & ~byte_strobe & ~stall;
   end
endmodule
`default_nettype wire

/* htsp_pkg.sv */
// Purpose: types and shared decode for host transfer stop pointer
// Assumes: nothing beyond the consts header
// Notes: no constants live here
`include "htsp_consts.svh"
package htsp_pkg;

   typedef enum logic [1:0] {
      HTSP_IDLE = 2'b00,
      HTSP_RUN  = 2'b01,
      HTSP_HALT = 2'b11
   } htsp_state_type;

   // high byte of a pointer as the buffer size lets it reach
   function automatic logic [7:0] htsp_mask_hi(input logic [7:0] hi, input logic [7:0] size);
      return hi & size;
   endfunction

   // index belongs to the register map
   function automatic logic htsp_mapped(input logic [7:0] idx);
      return (idx == `HTSP_IDX_DMA) || (idx == `HTSP_IDX_SIZE) || (idx == `HTSP_IDX_BMRST)
          || ((idx >= `HTSP_IDX_RPL) && (idx <= `HTSP_IDX_IMASK));
   endfunction

endpackage

/* htsp_ptr_cmp.sv */
// Purpose: stop pointer against active buffer pointer
// Assumes: size register holds the high byte mask
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module htsp_ptr_cmp
   import htsp_pkg::*;
(
   // compared values
   input  wire logic [15:0] ptr,
   input  wire logic [15:0] stop,
   input  wire logic [7:0]  size_mask,
   // result
   output logic             match
);

   logic lo_eq;
   logic hi_eq;

   assign lo_eq = (ptr[7:0] == stop[7:0]);
   assign hi_eq = (htsp_mask_hi(ptr[15:8], size_mask) == stop[15:8]);
   assign match = lo_eq && hi_eq;

endmodule
`default_nettype wire

/* htsp_top.sv */
// Purpose: buffer pointers and host transfer stop pointer with end-of-transfer halt
// Assumes: byte_strobe only while xfer_active; auto_cmd is a one-cycle pulse
// Notes:
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "htsp_consts.svh"
module htsp_top
   import htsp_pkg::*;
(
   // clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // axi write
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi read
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // host transfer side
   input  wire logic        auto_cmd,
   input  wire logic        byte_strobe,
   output logic             xfer_active,
   output logic             xfer_read,
   output logic [15:0]      buf_addr,
   // interrupt
   output logic             irq
);

   logic           wr_pulse;
   logic [7:0]     wr_idx;
   logic [7:0]     wr_data;
   logic [7:0]     rd_idx;
   logic [7:0]     rd_data;
   logic           wen_reg;
   logic           ren_reg;
   logic           done_reg;
   logic [7:0]     size_reg;
   logic           bmrst_reg;
   logic [15:0]    rp_reg;
   logic [15:0]    wp_reg;
   logic [15:0]    sp_reg;
   logic [1:0]     istat_reg;
   logic [1:0]     imask_reg;
   logic           irq_reg;
   logic           xfer_active_reg;
   logic           xfer_read_reg;
   logic [15:0]    buf_addr_reg;
   htsp_state_type state_reg;
   htsp_state_type state_next;
   logic           bm_clr;
   logic           match;
   logic           advance;
   logic           restart;
   logic           done_set;
   logic [15:0]    act_ptr;
   logic [15:0]    act_inc;

   function automatic logic wr_hit(input logic pulse, input logic [7:0] idx, input logic [7:0] target);
      return pulse && (idx == target);
   endfunction

   htsp_axil_slave u_slave (
      .aclk     (aclk),     .aresetn  (aresetn),  .ce       (ce),
      .awaddr   (awaddr),   .awvalid  (awvalid),  .awready  (awready),
      .wdata    (wdata),    .wstrb    (wstrb),    .wvalid   (wvalid),
      .wready   (wready),   .bresp    (bresp),    .bvalid   (bvalid),
      .bready   (bready),   .araddr   (araddr),   .arvalid  (arvalid),
      .arready  (arready),  .rdata    (rdata),    .rresp    (rresp),
      .rvalid   (rvalid),   .rready   (rready),   .wr_pulse (wr_pulse),
      .wr_idx   (wr_idx),   .wr_data  (wr_data),  .rd_idx   (rd_idx),
      .rd_data  (rd_data)
   );
   assign act_ptr = ren_reg ? rp_reg : wp_reg;
   htsp_ptr_cmp u_cmp (.ptr(act_ptr), .stop(sp_reg), .size_mask(size_reg), .match(match));
   // any reset-register write or held reset bit
   assign bm_clr   = wr_hit(wr_pulse, wr_idx, `HTSP_IDX_BMRST) || bmrst_reg;
   assign done_set = (state_reg == HTSP_RUN) && match;
   assign advance  = (state_reg == HTSP_RUN) && !match && byte_strobe;
   assign restart  = wr_hit(wr_pulse, wr_idx, `HTSP_IDX_SPH) && (wen_reg || ren_reg);
   // wrap: high byte confined to buffer size
   assign act_inc  = {htsp_mask_hi(act_ptr[15:8] + {7'h00, &act_ptr[7:0]}, size_reg), act_ptr[7:0] + 8'h01};

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         HTSP_IDLE:
            if (wen_reg || ren_reg)
               state_next = HTSP_RUN;
         HTSP_RUN:
            if (match)
               state_next = HTSP_HALT;
         HTSP_HALT:
            if (restart)
               state_next = HTSP_RUN;
         default:
            state_next = HTSP_IDLE;
      endcase
      if (bm_clr || !(wen_reg || ren_reg))
         state_next = HTSP_IDLE;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_reg <= HTSP_IDLE;
      else if (ce)
         state_reg <= state_next;
   end
   // control: enables, size, reset bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wen_reg   <= 1'b0;
         ren_reg   <= 1'b0;
         size_reg  <= `HTSP_SIZE_RST;
         bmrst_reg <= 1'b1;
      end
      else if (ce)
      begin
         if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_BMRST))
         begin
            bmrst_reg <= wr_data[`HTSP_BIT_BMRST];
            wen_reg   <= 1'b0;
            ren_reg   <= 1'b0;
         end
         else if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_DMA))
         begin
            wen_reg <= wr_data[`HTSP_BIT_WEN];
            ren_reg <= wr_data[`HTSP_BIT_REN];
         end
         if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_SIZE))
            size_reg <= wr_data;
      end
   end
   // done flag: set wins over write-one clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         done_reg <= 1'b0;
      else if (ce)
      begin
         if (done_set)
            done_reg <= 1'b1;
         else if (restart || bm_clr
                  || (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_DMA) && wr_data[`HTSP_BIT_DONE]))
            done_reg <= 1'b0;
      end
   end
   // read pointer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rp_reg <= `HTSP_PTR_CLR;
      else if (ce)
      begin
         if (bm_clr)
            rp_reg <= `HTSP_PTR_CLR;
         else if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_RPL))
            rp_reg[7:0] <= wr_data;
         else if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_RPH))
            rp_reg[15:8] <= wr_data;
         else if (advance && ren_reg)
            rp_reg <= act_inc;
      end
   end
   // write pointer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wp_reg <= `HTSP_PTR_CLR;
      else if (ce)
      begin
         if (bm_clr)
            wp_reg <= `HTSP_PTR_CLR;
         else if (auto_cmd)
            wp_reg <= `HTSP_PTR_CLR;
         else if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_WPL))
            wp_reg[7:0] <= wr_data;
         else if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_WPH))
            wp_reg[15:8] <= wr_data;
         else if (advance && !ren_reg)
            wp_reg <= act_inc;
      end
   end
   // stop pointer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sp_reg <= `HTSP_STOP_INIT;
      else if (ce)
      begin
         if (bm_clr)
            sp_reg <= `HTSP_STOP_INIT;
         else if (auto_cmd)
            sp_reg <= {`HTSP_SPH_INIT, `HTSP_SPL_AUTO};
         else if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_SPL))
            sp_reg[7:0] <= wr_data;
         else if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_SPH))
            sp_reg[15:8] <= wr_data;
      end
   end
   // interrupt status, mask and output
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         istat_reg <= 2'h0;
         imask_reg <= 2'h0;
         irq_reg   <= 1'b0;
      end
      else if (ce)
      begin
         for (int i = 0; i < 2; i++)
         begin
            if ((i == `HTSP_IRQ_DONE && done_set) || (i == `HTSP_IRQ_AUTO && auto_cmd))
               istat_reg[i] <= 1'b1;
            else if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_ISTAT) && wr_data[i])
               istat_reg[i] <= 1'b0;
         end
         if (wr_hit(wr_pulse, wr_idx, `HTSP_IDX_IMASK))
            imask_reg <= wr_data[1:0];
         irq_reg <= |(istat_reg & imask_reg);
      end
   end
   // host side outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         xfer_active_reg <= 1'b0;
         xfer_read_reg   <= 1'b0;
         buf_addr_reg    <= `HTSP_PTR_CLR;
      end
      else if (ce)
      begin
         xfer_active_reg <= (state_next == HTSP_RUN) && !advance;
         xfer_read_reg   <= ren_reg;
         buf_addr_reg    <= act_ptr;
      end
   end
   always_comb
   begin
      rd_data = 8'h00;
      unique case (rd_idx)
         `HTSP_IDX_DMA:   rd_data = {2'b00, done_reg, 1'b0, ren_reg, wen_reg, 2'b00};
         `HTSP_IDX_SIZE:  rd_data = size_reg;
         `HTSP_IDX_BMRST: rd_data = {7'h00, bmrst_reg};
         `HTSP_IDX_RPL:   rd_data = rp_reg[7:0];
         `HTSP_IDX_RPH:   rd_data = rp_reg[15:8];
         `HTSP_IDX_WPL:   rd_data = wp_reg[7:0];
         `HTSP_IDX_WPH:   rd_data = wp_reg[15:8];
         `HTSP_IDX_SPL:   rd_data = sp_reg[7:0];
         `HTSP_IDX_SPH:   rd_data = sp_reg[15:8];
         `HTSP_IDX_ISTAT: rd_data = {6'h00, istat_reg};
         `HTSP_IDX_IMASK: rd_data = {6'h00, imask_reg};
         default:         rd_data = 8'h00;
      endcase
   end
   assign xfer_active = xfer_active_reg;
   assign xfer_read   = xfer_read_reg;
   assign buf_addr    = buf_addr_reg;
   assign irq         = irq_reg;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   wph_clear_a: assert property (ce && bm_clr |=> wp_reg[15:8] == 8'h00)
      else $error("write pointer high not cleared");
   wph_auto_a: assert property (ce && !bm_clr && auto_cmd |=> wp_reg[15:8] == 8'h00)
      else $error("auto command left write pointer high");
   low_compare_a: assert property (ce && !bm_clr && state_reg == HTSP_RUN && !ren_reg && wen_reg
                                   && wp_reg[7:0] == sp_reg[7:0] && (wp_reg[15:8] & size_reg) == sp_reg[15:8]
                                   |=> state_reg == HTSP_HALT)
      else $error("write pointer reached stop without halt");
   spl_init_a: assert property (ce && bm_clr |=> sp_reg[7:0] == 8'hff)
      else $error("stop low not initialised");
   spl_auto_a: assert property (ce && !bm_clr && auto_cmd |=> sp_reg[7:0] == 8'hff)
      else $error("auto command stop low wrong");
   high_mask_a: assert property (ce && !bm_clr && state_reg == HTSP_RUN && ren_reg
                                 && rp_reg[7:0] == sp_reg[7:0] && (rp_reg[15:8] & size_reg) == sp_reg[15:8]
                                 |=> state_reg == HTSP_HALT)
      else $error("read pointer reached masked stop without halt");
   done_halt_a: assert property (ce && done_set && !bm_clr && (wen_reg || ren_reg)
                                 |=> done_reg && state_reg == HTSP_HALT ##1 !xfer_active)
      else $error("match did not halt transfer");
   restart_run_a: assert property (ce && state_reg == HTSP_HALT && restart && !bm_clr
                                   |=> state_reg == HTSP_RUN && !done_reg)
      else $error("stop high write did not restart");
   sph_init_a: assert property (ce && bm_clr |=> sp_reg[15:8] == 8'h01)
      else $error("stop high not one after reset");
   sph_auto_a: assert property (ce && !bm_clr && auto_cmd |=> sp_reg[15:8] == 8'h01)
      else $error("auto command stop high wrong");
   bm_reset_a: assert property (ce && wr_hit(wr_pulse, wr_idx, `HTSP_IDX_BMRST)
                                |=> state_reg == HTSP_IDLE && !wen_reg && !ren_reg && sp_reg == 16'h01ff)
      else $error("reset register write incomplete");
   rp_clear_a: assert property (ce && bm_clr |=> rp_reg == 16'h0000)
      else $error("read pointer not cleared");
   rp_step_a: assert property (ce && advance && ren_reg && !bm_clr && !wr_pulse
                               |=> rp_reg[7:0] == $past(rp_reg[7:0]) + 8'h01)
      else $error("read pointer did not advance");

   run_halt_c: cover property (state_reg == HTSP_RUN ##1 state_reg == HTSP_HALT);
   restart_c: cover property (state_reg == HTSP_HALT && restart);
   auto_cmd_c: cover property (ce && auto_cmd && state_reg == HTSP_IDLE);
   irq_c: cover property (irq);

endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the host transfer stop pointer block
// Assumes: AXI4-Lite master by tasks, expected answers queued
// Notes: a monitor process compares bus answers with the oldest note
`timescale 1ns/1ps
`default_nettype none
`include "htsp_consts.svh"
module tb_top;
   import htsp_pkg::*;
   logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, auto_cmd, go, stall;
   logic        awready, wready, bvalid, arready, rvalid, xfer_active, xfer_read, irq, byte_strobe;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, lfsr;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [15:0] buf_addr;
   logic [1:0]  wq [$];
   logic [33:0] rq [$];
   logic [7:0]  ti [4];
   logic [7:0]  tv [4];
   logic [7:0]  tx [4];
   int          errors, n_checks;

   htsp_top htsp_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .auto_cmd(auto_cmd), .byte_strobe(byte_strobe),
      .xfer_active(xfer_active), .xfer_read(xfer_read), .buf_addr(buf_addr), .irq(irq));
   htsp_host_model htsp_host_model_inst (.aclk(aclk), .aresetn(aresetn), .go(go), .stall(stall),
      .xfer_active(xfer_active), .byte_strobe(byte_strobe));

   always #20 aclk = ~aclk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   always @(posedge aclk)
   begin
      lfsr <= lfsr_next(lfsr);
      stall <= lfsr[0] & lfsr[3];
   end

   task automatic check(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // bus answers against the oldest note
   always @(posedge aclk)
   begin
      if (bvalid === 1'b1 && bready === 1'b1)
         check(wq.size() != 0 && bresp === wq.pop_front(), "write response");
      if (rvalid === 1'b1 && rready === 1'b1)
         check(rq.size() != 0 && {rresp, rdata} === rq.pop_front(), "read data");
   end

   task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = `HTSP_RESP_OKAY);
      int t;
      @(posedge aclk);
      wq.push_back(er);
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= {lfsr[23:0], d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      t = 0;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         t++;
      end while (bvalid !== 1'b1 && t < 100);
      bready <= 1'b0;
      awaddr <= ~awaddr;
      wdata <= ~wdata;
      if (t >= 100) check(1'b0, "write timeout");
   endtask

   task automatic axi_read(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = `HTSP_RESP_OKAY);
      int t;
      @(posedge aclk);
      rq.push_back({er, 24'h000000, d});
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      t = 0;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         t++;
      end while (rvalid !== 1'b1 && t < 100);
      rready <= 1'b0;
      araddr <= ~araddr;
      if (t >= 100) check(1'b0, "read timeout");
   endtask

   task automatic regs_wr();
      for (int i = 0; i < 4; i++) axi_write(ti[i], tv[i]);
   endtask

   task automatic regs_rd(input bit init);
      for (int i = 0; i < 4; i++) axi_read(ti[i], init ? tx[i] : tv[i]);
   endtask

   task automatic wait_irq();
      int t;
      t = 0;
      while (irq !== 1'b1 && t < 300)
      begin
         @(posedge aclk);
         t++;
      end
      check(irq === 1'b1, "transfer did not end");
   endtask

   initial
   begin
      #(40 * 20000);
      check(1'b0, "watchdog");
      finish_test();
   end

   initial
   begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, auto_cmd, go, stall} = '0;
      {awaddr, araddr, wdata} = '0;
      {ce, wstrb, lfsr, errors, n_checks} = {1'b1, 4'hf, 32'hdbbb, 32'd0, 32'd0};
      ti = '{`HTSP_IDX_WPH, `HTSP_IDX_SPL, `HTSP_IDX_SPH, `HTSP_IDX_RPH};
      tv = '{8'h12, 8'h33, 8'h05, 8'h07};
      tx = '{8'h00, 8'hff, 8'h01, 8'h00};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      regs_rd(1);
      axi_read(8'h70, 8'h00, `HTSP_RESP_SLVERR);
      axi_write(8'h70, 8'h5a, `HTSP_RESP_SLVERR);
      regs_wr();
      regs_rd(1);
      $display("test reset values done");
      axi_write(`HTSP_IDX_BMRST, 8'h00);
      regs_wr();
      regs_rd(0);
      axi_write(`HTSP_IDX_BMRST, 8'h00);
      regs_rd(1);
      $display("test reset register done");
      regs_wr();
      axi_write(`HTSP_IDX_IMASK, 8'h00);
      @(posedge aclk);
      auto_cmd <= 1'b1;
      @(posedge aclk);
      auto_cmd <= 1'b0;
      axi_read(`HTSP_IDX_WPH, 8'h00);
      axi_read(`HTSP_IDX_SPL, 8'hff);
      axi_read(`HTSP_IDX_SPH, 8'h01);
      axi_read(`HTSP_IDX_RPH, 8'h07);
      check(irq === 1'b0, "masked irq seen");
      axi_write(`HTSP_IDX_IMASK, 8'h02);
      repeat (2) @(posedge aclk);
      check(irq === 1'b1, "irq missing");
      axi_write(`HTSP_IDX_ISTAT, 8'h02);
      repeat (2) @(posedge aclk);
      check(irq === 1'b0, "irq not cleared");
      $display("test auto command done");
      axi_write(`HTSP_IDX_IMASK, 8'h01);
      axi_write(`HTSP_IDX_SIZE, 8'hff);
      axi_write(`HTSP_IDX_SPL, 8'h03);
      axi_write(`HTSP_IDX_SPH, 8'h00);
      go <= 1'b1;
      axi_write(`HTSP_IDX_DMA, 8'h04);
      wait_irq();
      axi_read(`HTSP_IDX_WPL, 8'h03);
      axi_read(`HTSP_IDX_DMA, 8'h24);
      repeat (12) @(posedge aclk);
      check(xfer_active === 1'b0 && buf_addr === 16'h0003 && xfer_read === 1'b0, "no halt");
      $display("test write transfer done");
      axi_write(`HTSP_IDX_ISTAT, 8'h01);
      axi_write(`HTSP_IDX_SPL, 8'h06);
      axi_write(`HTSP_IDX_SPH, 8'h00);
      wait_irq();
      axi_read(`HTSP_IDX_WPL, 8'h06);
      $display("test restart done");
      axi_write(`HTSP_IDX_BMRST, 8'h00);
      axi_write(`HTSP_IDX_RPL, 8'hfe);
      axi_write(`HTSP_IDX_RPH, 8'h01);
      axi_write(`HTSP_IDX_SPL, 8'h01);
      axi_write(`HTSP_IDX_SPH, 8'h00);
      axi_write(`HTSP_IDX_SIZE, 8'h01);
      axi_write(`HTSP_IDX_ISTAT, 8'h01);
      axi_write(`HTSP_IDX_DMA, 8'h08);
      wait_irq();
      axi_read(`HTSP_IDX_RPL, 8'h01);
      axi_read(`HTSP_IDX_RPH, 8'h00);
      check(xfer_read === 1'b1 && buf_addr === 16'h0001, "read pointer stop");
      $display("test masked read done");
      axi_write(`HTSP_IDX_DMA, 8'h28);
      axi_read(`HTSP_IDX_DMA, 8'h08);
      wstrb <= 4'he;
      axi_write(`HTSP_IDX_SPL, 8'h55);
      wstrb <= 4'hf;
      axi_read(`HTSP_IDX_SPL, 8'h01);
      @(posedge aclk);
      ce <= 1'b0;
      auto_cmd <= 1'b1;
      repeat (3) @(posedge aclk);
      ce <= 1'b1;
      auto_cmd <= 1'b0;
      axi_read(`HTSP_IDX_SPL, 8'h01);
      axi_read(`HTSP_IDX_ISTAT, 8'h01);
      $display("test control paths done");
      finish_test();
   end
endmodule
`default_nettype wire
